// *** verilog/fsw_pkg.sv ***
/*
 * Constants and carrier types of the fail-safe watchdog unit.
 * Assumes a single 200 MHz system clock shared by every user of it.
 */
`default_nettype none

package fsw_pkg;

    // ********************************************************
    // Clock and timing
    // ********************************************************
    localparam int CLK_MHZ = 200;
    localparam int STABLE_TIME_MS = 1;
    localparam int STABLE_CYCLES_DEF = STABLE_TIME_MS * 1000 * CLK_MHZ;
    localparam int POR_TYP_US = 18;
    localparam int POR_MAX_US = 34;
    localparam int POR_CYCLES = POR_TYP_US * CLK_MHZ;
    localparam int POR_MAX_CYCLES = POR_MAX_US * CLK_MHZ;
    localparam logic [11:0] POR_LAST = 12'(POR_CYCLES - 1);

    // ********************************************************
    // Watchdog counter
    // ********************************************************
    localparam int MC_DIV = 12;
    localparam logic [3:0] MC_LAST = 4'(MC_DIV - 1);
    localparam int WD_WIDTH = 15;
    localparam logic [14:0] WD_TIMEOUT = 15'h7ffc;
    localparam logic [3:0] PRE16_LAST = 4'hf;
    localparam logic [7:0] WD_RST_SHORT = 8'h08;
    localparam logic [7:0] WD_RST_LONG = 8'h80;
    localparam int PRESCALE_BIT = 7;
    localparam logic [7:0] RELOAD_RESET = 8'h00;
    localparam logic [7:0] RELOAD_LOW = 8'h00;

    // ********************************************************
    // Clock monitor
    // ********************************************************
    localparam int RC_RATIO = 5;
    localparam logic [2:0] RC_LAST = 3'(RC_RATIO - 1);

    typedef enum logic [1:0] {
        MON_POR,
        MON_FAIL,
        MON_SETTLE,
        MON_OK
    } mon_state_t;

    // One software instruction acting on the control register.
    typedef struct packed {
        logic valid;
        logic refresh;
        logic start;
        logic clear_flag;
        logic reload_wr;
        logic [7:0] reload_data;
    } sw_op_t;

    typedef struct packed {
        logic wd_reset;
        logic monitor_reset;
        logic chip_reset;
        logic ports_reset;
        logic clock_sel_rc;
        logic sys_tick;
        logic reset_state_ready;
        logic wd_reset_flag;
        logic clock_fail_flag;
        logic wd_running;
        logic [14:0] wd_count;
    } status_t;

endpackage

`default_nettype wire

// *** verilog/fail_safe_watchdog_unit.sv ***
/*
 * Software watchdog counter and oscillator monitor with fast reset.
 * Assumes osc_in and rc_in are raw pins, far slower than clk, and that
 * each software instruction touching the control bits is one sw_op pulse.
 */
//
// Overview of operation
// - Fifteen-bit up-counter ticking at machine rate over two or thirty-two.
// - Divide-by-two always; extra divide-by-sixteen when reload bit seven is set.
// - Start bit runs the counter; software can never stop it afterwards.
// - Counter halts in idle, power-down or during a monitor reset.
// - Refresh needs refresh bit then start bit in consecutive instructions.
// - Reaching 7ffc without refresh raises the internal watchdog reset.
// - Watchdog reset lasts 8 count ticks, or 128 with large prescaler.
// - Watchdog reset keeps the counter running and sets its status flag.
// - Watchdog flag cleared by external reset or software; set only by timeout.
// - Monitor keeps comparing main oscillator against the RC reference.
// - Main below RC over five: select RC clock and assert reset.
// - Monitor reset keeps watchdog flag and sets the clock fail flag.
// - Healthy main oscillator feeds the system clock divided by two.
// - After a failure clears, a 1 ms settle reset phase runs.
// - Main oscillator counts as failed until it starts after power-on.
// - Ports held in reset state from power-on before the oscillator runs.
// - Correct reset state reached 18 us typical, 34 us at most.
`timescale 1ns/1ps
`default_nettype none

module fail_safe_watchdog_unit #(
    parameter int STABLE_CYCLES = fsw_pkg::STABLE_CYCLES_DEF
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic osc_in,
    input wire logic rc_in,
    input wire logic idle_mode,
    input wire logic power_down,
    input wire fsw_pkg::sw_op_t sw_op,
    output fsw_pkg::status_t status
);
    import fsw_pkg::*;

    localparam int SW = $clog2(STABLE_CYCLES + 1);
    localparam logic [SW-1:0] SETTLE_LAST = SW'(STABLE_CYCLES - 1);

    typedef struct packed {
        logic osc_s1;
        logic osc_s2;
        logic osc_s3;
        logic rc_s1;
        logic rc_s2;
        logic rc_s3;
        logic [3:0] mc_cnt;
        logic pre2;
        logic [3:0] pre16;
        logic [7:0] reload;
        logic armed;
        logic running;
        logic [14:0] wd_cnt;
        logic wd_rst_active;
        logic [7:0] wd_rst_cnt;
        logic wd_flag;
        logic fail_flag;
        logic [2:0] rc_win;
        logic osc_seen;
        mon_state_t mon;
        logic [SW-1:0] settle_cnt;
        logic sys_div;
        logic sys_tick;
        logic [11:0] por_cnt;
        logic ready;
    } state_t;

    state_t st;
    state_t next_st;
    logic osc_tick;
    logic rc_tick;
    logic cyc_tick;
    logic cnt_tick;
    logic halt;
    logic op_ok;
    logic refresh_now;
    logic timeout_now;
    logic win_end;
    logic good;
    logic sel_rc;
    logic [7:0] rst_len;
    logic [14:0] reload_base;

    // ********************************************************
    // Combinational next state
    // ********************************************************
    always_comb begin
        next_st = st;
        next_st.osc_s1 = osc_in;
        next_st.osc_s2 = st.osc_s1;
        next_st.osc_s3 = st.osc_s2;
        next_st.rc_s1 = rc_in;
        next_st.rc_s2 = st.rc_s1;
        next_st.rc_s3 = st.rc_s2;
        osc_tick = st.osc_s2 & ~st.osc_s3;
        rc_tick = st.rc_s2 & ~st.rc_s3;
        halt = idle_mode | power_down | (st.mon != MON_OK);
        reload_base = {st.reload[6:0], RELOAD_LOW};
        rst_len = st.reload[PRESCALE_BIT] ? WD_RST_LONG : WD_RST_SHORT;

        // Machine cycle is the main oscillator over twelve.
        cyc_tick = 1'b0;
        if (osc_tick) begin
            if (st.mc_cnt == MC_LAST) begin
                next_st.mc_cnt = '0;
                cyc_tick = 1'b1;
            end else begin
                next_st.mc_cnt = st.mc_cnt + 4'h1;
            end
        end

        cnt_tick = 1'b0;
        if (cyc_tick && !halt) begin
            next_st.pre2 = ~st.pre2;
            if (st.pre2) begin
                if (!st.reload[PRESCALE_BIT]) begin
                    cnt_tick = 1'b1;
                end else begin
                    next_st.pre16 = st.pre16 + 4'h1;
                    cnt_tick = (st.pre16 == PRE16_LAST);
                end
            end
        end

        // Software is ignored while the chip itself sits in reset.
        op_ok = sw_op.valid & ~st.wd_rst_active & (st.mon == MON_OK);
        refresh_now = op_ok & sw_op.start & st.armed & st.running;
        if (op_ok) begin
            next_st.armed = sw_op.refresh;
            if (sw_op.reload_wr) begin
                next_st.reload = sw_op.reload_data;
            end
            if (sw_op.start) begin
                next_st.running = 1'b1;
            end
        end

        timeout_now = st.running & ~st.wd_rst_active & ~refresh_now &
                      (st.wd_cnt == WD_TIMEOUT);
        if (refresh_now) begin
            next_st.wd_cnt = reload_base;
        end else if (st.wd_rst_active) begin
            if (cnt_tick) begin
                if (st.wd_rst_cnt == rst_len - 8'h01) begin
                    next_st.wd_rst_active = 1'b0;
                    next_st.wd_rst_cnt = '0;
                    next_st.wd_cnt = reload_base;
                    next_st.armed = 1'b0;
                end else begin
                    next_st.wd_rst_cnt = st.wd_rst_cnt + 8'h01;
                end
            end
        end else if (timeout_now) begin
            next_st.wd_rst_active = 1'b1;
            next_st.wd_rst_cnt = '0;
        end else if (st.running && cnt_tick) begin
            next_st.wd_cnt = st.wd_cnt + 15'h0001;
        end

        // A timeout in the same cycle as a software clear keeps the flag.
        if (timeout_now) begin
            next_st.wd_flag = 1'b1;
        end else if (op_ok && sw_op.clear_flag) begin
            next_st.wd_flag = 1'b0;
        end

        // ********************************************************
        // Clock monitor
        // ********************************************************
        // A window spans five RC edges; no main edge in it means
        // the main oscillator runs below a fifth of the reference.
        win_end = rc_tick & (st.rc_win == RC_LAST);
        good = st.osc_seen | osc_tick;
        next_st.osc_seen = good;
        if (rc_tick) begin
            if (win_end) begin
                next_st.rc_win = '0;
                next_st.osc_seen = 1'b0;
            end else begin
                next_st.rc_win = st.rc_win + 3'h1;
            end
        end

        unique case (st.mon)
            MON_POR, MON_FAIL: begin
                if (win_end && good) begin
                    next_st.mon = MON_SETTLE;
                    next_st.settle_cnt = '0;
                end
            end
            MON_SETTLE: begin
                if (win_end && !good) begin
                    next_st.mon = MON_FAIL;
                    next_st.fail_flag = 1'b1;
                end else if (st.settle_cnt == SETTLE_LAST) begin
                    next_st.mon = MON_OK;
                end else begin
                    next_st.settle_cnt = st.settle_cnt + SW'(1);
                end
            end
            MON_OK: begin
                if (win_end && !good) begin
                    next_st.mon = MON_FAIL;
                    next_st.fail_flag = 1'b1;
                end
            end
        endcase

        // The RC clock stands in while the main oscillator is absent.
        sel_rc = (st.mon == MON_POR) | (st.mon == MON_FAIL);
        if (osc_tick) begin
            next_st.sys_div = ~st.sys_div;
        end
        next_st.sys_tick = sel_rc ? rc_tick : (osc_tick & st.sys_div);

        // Fast reset: the reset state is flagged by a counter of clk cycles,
        // without waiting for the crystal, a fixed delay after power-on.
        if (!st.ready) begin
            if (st.por_cnt == POR_LAST) begin
                next_st.ready = 1'b1;
            end else begin
                next_st.por_cnt = st.por_cnt + 12'h001;
            end
        end
    end

    // ********************************************************
    // State register
    // ********************************************************
    // External reset clears both flags; only it can, for the fail flag.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // ********************************************************
    // Outputs
    // ********************************************************
    assign status.wd_reset = st.wd_rst_active;
    assign status.monitor_reset = (st.mon != MON_OK);
    assign status.chip_reset = st.wd_rst_active | (st.mon != MON_OK);
    assign status.ports_reset = st.wd_rst_active | (st.mon != MON_OK);
    assign status.clock_sel_rc = (st.mon == MON_POR) | (st.mon == MON_FAIL);
    assign status.sys_tick = st.sys_tick;
    assign status.reset_state_ready = st.ready;
    assign status.wd_reset_flag = st.wd_flag;
    assign status.clock_fail_flag = st.fail_flag;
    assign status.wd_running = st.running;
    assign status.wd_count = st.wd_cnt;

    // ********************************************************
    // Assertions
    // ********************************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    sequence refresh_step_s;
        op_ok && sw_op.refresh && !sw_op.start;
    endsequence

    sequence start_step_s;
        op_ok && sw_op.start && st.running;
    endsequence

    start_runs_a: assert property (
        op_ok && sw_op.start |=> st.running)
        else $error("start bit did not run the counter");

    never_stops_a: assert property (
        st.running |=> st.running)
        else $error("watchdog counter stopped");

    halt_hold_a: assert property (
        (idle_mode || power_down) && !op_ok && !st.wd_rst_active
        |=> $stable(st.wd_cnt))
        else $error("counter moved while halted");

    refresh_seq_a: assert property (
        refresh_step_s ##1 start_step_s |=> st.wd_cnt == $past(reload_base))
        else $error("refresh sequence did not reload");

    lone_start_a: assert property (
        op_ok && !sw_op.refresh ##1 op_ok && sw_op.start && !st.armed
        && st.running && cnt_tick && !st.wd_rst_active && !timeout_now
        |=> st.wd_cnt == $past(st.wd_cnt) + 15'h0001)
        else $error("lone start bit refreshed the counter");

    timeout_rst_a: assert property (
        timeout_now |=> st.wd_rst_active && st.wd_flag)
        else $error("timeout did not raise reset and flag");

    rst_len_a: assert property (
        $fell(st.wd_rst_active) |->
        $past(st.wd_rst_cnt) == $past(rst_len) - 8'h01)
        else $error("watchdog reset length wrong");

    keeps_run_a: assert property (
        $fell(st.wd_rst_active) |-> st.running && st.wd_flag)
        else $error("watchdog reset stopped counter or lost flag");

    flag_clear_a: assert property (
        op_ok && sw_op.clear_flag && !timeout_now |=> !st.wd_flag)
        else $error("software clear of flag failed");

    mon_fail_a: assert property (
        st.mon == MON_OK && win_end && !good
        |=> status.clock_sel_rc && status.monitor_reset
        && st.fail_flag && $stable(st.wd_flag))
        else $error("oscillator failure not handled");

    settle_a: assert property (
        $rose(st.mon == MON_OK) |->
        $past(st.mon) == MON_SETTLE && $past(st.settle_cnt) == SETTLE_LAST)
        else $error("settle phase skipped or cut short");

    sys_clk_a: assert property (
        !sel_rc && osc_tick && st.sys_div |=> st.sys_tick)
        else $error("system tick not main oscillator over two");

    por_ready_a: assert property (
        $rose(st.ready) |-> $past(st.por_cnt) == POR_LAST)
        else $error("fast reset delay wrong");

    flag_source_a: assert property (
        $rose(st.wd_flag) |-> $past(timeout_now))
        else $error("watchdog flag set without a timeout");

    rc_tick_a: assert property (
        sel_rc && rc_tick |=> st.sys_tick)
        else $error("system tick not taken from the RC clock");

endmodule

`default_nettype wire

// *** tb/tb_top.sv ***
/*
 * Self-checking bench of the fail-safe watchdog unit.
 * Assumes the unit's ports only; oscillator pins come from this bench.
 */
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    import fsw_pkg::*;

    // ****************************************************************
    // Stimulus and clocks
    // ****************************************************************
    typedef struct packed {
        sw_op_t op;
        logic run;
        logic [14:0] cnt;
        logic use_cnt;
    } row_t;

    logic clk = 1'b0;
    logic rst = 1'b1;
    logic osc_in = 1'b0;
    logic rc_in = 1'b0;
    logic idle_mode = 1'b0;
    logic power_down = 1'b0;
    logic osc_run = 1'b0;
    sw_op_t sw_op = '0;
    status_t status;
    int err_count = 0;
    int samples_checked = 0;
    int n;
    int t;
    logic [14:0] hold;
    row_t rows [6];

    fail_safe_watchdog_unit #(.STABLE_CYCLES(20)) fail_safe_watchdog_unit_inst (
        .clk(clk), .rst(rst), .osc_in(osc_in), .rc_in(rc_in),
        .idle_mode(idle_mode), .power_down(power_down),
        .sw_op(sw_op), .status(status));

    initial begin
        forever #2.5 clk = ~clk;
    end

    // The main pin toggles every 3 clocks, the RC pin every 10.
    always #15 if (osc_run) osc_in = ~osc_in;
    always #50 rc_in = ~rc_in;

    // ****************************************************************
    // Tasks
    // ****************************************************************
    function automatic sw_op_t mk(logic r, logic s, logic c, logic w,
                                  logic [7:0] d);
        return '{1'b1, r, s, c, w, d};
    endfunction

    task automatic check(string name, logic [14:0] seen, logic [14:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic do_op(sw_op_t op);
        @(negedge clk) sw_op = op;
        @(negedge clk) sw_op = '0;
    endtask

    task automatic count_ticks(output int k);
        k = 0;
        repeat (600) begin
            @(negedge clk);
            if (status.sys_tick === 1'b1) k++;
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // ****************************************************************
    // Watchdog
    // ****************************************************************
    initial begin
        #450000;
        err_count++;
        give_verdict();
    end

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        rows[0] = '{mk(0, 0, 0, 1, 8'h7f), 1'b0, 15'h0000, 1'b1};
        rows[1] = '{mk(0, 1, 0, 0, 8'h00), 1'b1, 15'h0000, 1'b0};
        rows[2] = '{mk(1, 0, 0, 0, 8'h00), 1'b1, 15'h0000, 1'b0};
        rows[3] = '{mk(0, 1, 0, 0, 8'h00), 1'b1, 15'h7f00, 1'b1};
        rows[4] = '{mk(1, 0, 0, 0, 8'h00), 1'b1, 15'h0000, 1'b0};
        rows[5] = '{mk(0, 1, 0, 0, 8'h00), 1'b1, 15'h7f00, 1'b1};
        repeat (4) @(negedge clk);
        check("reset flag", status.wd_reset_flag, 0);
        check("reset fail flag", status.clock_fail_flag, 0);
        rst = 1'b0;
        // Main oscillator still silent: the RC clock must hold the reset.
        repeat (300) @(negedge clk);
        check("por rc sel", status.clock_sel_rc, 1);
        check("por ports", status.ports_reset, 1);
        check("por chip", status.chip_reset, 1);
        osc_run = 1'b1;
        for (t = 300; t < 3500 && status.monitor_reset !== 1'b0; t++)
            @(negedge clk);
        check("por release", status.monitor_reset, 0);
        check("por main sel", status.clock_sel_rc, 0);
        repeat (3500 - t) @(negedge clk);
        check("ready early", status.reset_state_ready, 0);
        repeat (200) @(negedge clk);
        check("ready late", status.reset_state_ready, 1);
        foreach (rows[i]) begin
            do_op(rows[i].op);
            check("running", status.wd_running, rows[i].run);
            if (rows[i].use_cnt)
                check("reload", status.wd_count, rows[i].cnt);
        end
        // A foreign instruction between the two bits breaks the pair.
        do_op(mk(0, 0, 0, 1, 8'h10));
        do_op(mk(1, 0, 0, 0, 8'h00));
        do_op(mk(0, 0, 1, 0, 8'h00));
        do_op(mk(0, 1, 0, 0, 8'h00));
        check("split pair", status.wd_count === 15'h1000, 0);
        for (int i = 0; i < 2; i++) begin
            @(negedge clk);
            idle_mode = (i == 0);
            power_down = (i == 1);
            @(negedge clk) hold = status.wd_count;
            repeat (400) @(negedge clk);
            check("halted", status.wd_count, hold);
            check("still on", status.wd_running, 1);
        end
        idle_mode = 1'b0;
        power_down = 1'b0;
        do_op(mk(0, 0, 0, 1, 8'h7f));
        do_op(mk(1, 0, 0, 0, 8'h00));
        do_op(mk(0, 1, 0, 0, 8'h00));
        // From 7f00 to 7ffc is 252 ticks of 24 main edges, 144 clocks each.
        for (t = 0; t < 37000 && status.wd_reset !== 1'b1; t++)
            @(negedge clk);
        check("timeout", t > 36100 && t < 36440, 1);
        check("wd flag", status.wd_reset_flag, 1);
        check("wd chip", status.chip_reset, 1);
        for (t = 0; t < 1300 && status.wd_reset !== 1'b0; t++)
            @(negedge clk);
        check("wd length", t > 1140 && t < 1160, 1);
        check("restart", status.wd_count, 15'h7f00);
        check("kept on", status.wd_running, 1);
        osc_run = 1'b0;
        for (t = 0; t < 2000 && status.clock_sel_rc !== 1'b1; t++)
            @(negedge clk);
        check("fail sel", status.clock_sel_rc, 1);
        check("fail reset", status.monitor_reset, 1);
        check("fail flag", status.clock_fail_flag, 1);
        check("wd flag kept", status.wd_reset_flag, 1);
        hold = status.wd_count;
        count_ticks(n);
        check("rc ticks", n >= 29 && n <= 31, 1);
        check("fail halt", status.wd_count, hold);
        osc_run = 1'b1;
        for (t = 0; t < 2000 && status.clock_sel_rc !== 1'b0; t++)
            @(negedge clk);
        check("back main", status.clock_sel_rc, 0);
        for (t = 0; t < 100 && status.monitor_reset !== 1'b0; t++)
            @(negedge clk);
        check("settle", t >= 19 && t <= 24, 1);
        count_ticks(n);
        check("main ticks", n >= 49 && n <= 51, 1);
        do_op(mk(0, 0, 1, 0, 8'h00));
        check("sw clear", status.wd_reset_flag, 0);
        check("fail sticky", status.clock_fail_flag, 1);
        // Large prescaler: one count per 2304 clocks, so two or three here.
        do_op(mk(0, 0, 0, 1, 8'hff));
        do_op(mk(1, 0, 0, 0, 8'h00));
        do_op(mk(0, 1, 0, 0, 8'h00));
        repeat (4700) @(negedge clk);
        check("slow rate", status.wd_count >= 15'h7f02 &&
              status.wd_count <= 15'h7f03, 1);
        // A hardware reset in mid-run stops the counter, unlike its own.
        @(negedge clk) rst = 1'b1;
        @(negedge clk);
        check("rst stops", status.wd_running, 0);
        check("rst count", status.wd_count, 0);
        check("rst fail flag", status.clock_fail_flag, 0);
        check("rst wd flag", status.wd_reset_flag, 0);
        rst = 1'b0;
        repeat (2) @(negedge clk);
        check("rst rc sel", status.clock_sel_rc, 1);
        check("rst ports", status.ports_reset, 1);
        give_verdict();
    end

endmodule

`default_nettype wire
